/* File: rtl/asu_cfg.svh */
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH
// register addresses
`define ASU_ADDR_MODE     16'hFF70
`define ASU_ADDR_STATUS   16'hFF71
`define ASU_ADDR_SYNC     16'hFF72
`define ASU_ADDR_BAUD     16'hFF73
`define ASU_ADDR_DATA     16'hFF74
// reset values
`define ASU_RST_MODE      8'h00
`define ASU_RST_SYNC      8'h00
`define ASU_RST_BAUD      8'h00
// mode register fields
`define ASU_MODE_TXE      7
`define ASU_MODE_RXE      6
`define ASU_MODE_PAR_HI   5
`define ASU_MODE_PAR_LO   4
`define ASU_MODE_CL       3
`define ASU_MODE_SL       2
// sync register writable bits (4 and 5 reserved)
`define ASU_SYNC_MASK     8'hCF
// baud field position
`define ASU_BAUD_SEL_LO   4
// timing: last tick count of a bit (8 ticks) and of a half bit (4 ticks)
`define ASU_TICKS_BIT     3'h7
`define ASU_TICKS_HALF    3'h3
`endif

/* File: rtl/asu_pkg.sv */
package asu_pkg;
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} asu_par_e;
  // frame format decoded from the mode register
  typedef struct packed {
    logic     tx_en;
    logic     rx_en;
    asu_par_e par;
    logic     len8;
    logic     stop2;
  } asu_fmt_s;
  // receive error status
  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
  } asu_err_s;
endpackage

/* File: rtl/asu_uart.sv */
`timescale 1ns/100ps
`include "asu_cfg.svh"
module asu_uart (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // cpu register port
  input  wire logic [15:0]  addr_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  input  wire logic [7:0]   wdata_i,
  output logic [7:0]        rdata_o,
  output logic              tx_space_o,
  // events
  output logic              tx_done_irq_o,
  output logic              tx_done_flag_o,
  output logic              rx_done_irq_o,
  // serial pins
  input  wire logic         rx_line_pin_i,
  output logic              txd_o
);
  import asu_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asu_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asu_rx_e;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // parity bit to send, or expected on receive, for a character
  function automatic logic par_bit(input logic [7:0] d, input asu_par_e p, input logic len8);
    logic ones;
    ones = ^{d[7] & len8, d[6:0]};
    case (p)
      PAR_EVEN: par_bit = ones;
      PAR_ODD:  par_bit = ~ones;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  mode_ff;
  logic [7:0]  sync_serial_mode_control_ff;
  logic [7:0]  baud_divider_ff;
  logic [7:0]  rx_buffer_ff;
  asu_err_s    rx_error_status_ff;
  logic        rx_unread_ff;
  asu_fmt_s    fmt;
  logic        wr_mode;
  logic        wr_data;
  logic        rd_data;

  assign fmt = '{tx_en: mode_ff[`ASU_MODE_TXE],
                 rx_en: mode_ff[`ASU_MODE_RXE],
                 par:   asu_par_e'(mode_ff[`ASU_MODE_PAR_HI:`ASU_MODE_PAR_LO]),
                 len8:  mode_ff[`ASU_MODE_CL],
                 stop2: mode_ff[`ASU_MODE_SL]};
  assign wr_mode   = wr_i && (addr_i == `ASU_ADDR_MODE);
  assign wr_data   = wr_i && (addr_i == `ASU_ADDR_DATA);
  assign rd_data   = rd_i && (addr_i == `ASU_ADDR_DATA);

  // configuration writes; low bits of mode and baud are fixed zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_ff                     <= `ASU_RST_MODE;
      sync_serial_mode_control_ff <= `ASU_RST_SYNC;
      baud_divider_ff             <= `ASU_RST_BAUD;
    end else if (wr_i) begin
      if (wr_mode)
        mode_ff <= {wdata_i[7:2], 2'b00};
      if (addr_i == `ASU_ADDR_SYNC)
        sync_serial_mode_control_ff <= wdata_i & `ASU_SYNC_MASK;
      if (addr_i == `ASU_ADDR_BAUD)
        baud_divider_ff <= {wdata_i[7:4], 4'h0};
    end
  end

  // read data is registered, one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ASU_ADDR_MODE:   rdata_o <= mode_ff;
        `ASU_ADDR_STATUS: rdata_o <= {5'h00, rx_error_status_ff};
        `ASU_ADDR_SYNC:   rdata_o <= sync_serial_mode_control_ff;
        `ASU_ADDR_BAUD:   rdata_o <= baud_divider_ff;
        `ASU_ADDR_DATA:   rdata_o <= rx_buffer_ff;
        default:          rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // baud tick: one pulse every 2^(n+1) clocks, n = field + 1
  // ----------------------------------------------------------------
  logic [9:0] pre_ff;
  logic [9:0] pre_mask;
  logic       tick;

  assign pre_mask = 10'((11'h004 << baud_divider_ff[6:4]) - 11'h001);
  assign tick     = ((pre_ff & pre_mask) == pre_mask);

  // free-running prescaler; divider writes mid-frame disturb timing
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      pre_ff <= 10'h000;
    else
      pre_ff <= pre_ff + 10'h001;
  end

  // ----------------------------------------------------------------
  // transmit buffer: two entries between cpu writes and shifter
  // ----------------------------------------------------------------
  logic [7:0] tbuf_mem [0:1];
  logic       tbuf_wp_ff;
  logic       tbuf_rp_ff;
  logic [1:0] tbuf_cnt_ff;
  logic       tbuf_push;
  logic       tbuf_pop;
  logic       tbuf_valid;

  assign tbuf_valid = (tbuf_cnt_ff != 2'h0);
  assign tbuf_push  = wr_data && tx_space_o;   // a write with no space is dropped
  // pointers and occupancy; space flag kept as its own flip-flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tbuf_wp_ff  <= 1'b0;
      tbuf_rp_ff  <= 1'b0;
      tbuf_cnt_ff <= 2'h0;
      tx_space_o  <= 1'b1;
    end else begin
      if (tbuf_push)
        tbuf_wp_ff <= ~tbuf_wp_ff;
      if (tbuf_pop)
        tbuf_rp_ff <= ~tbuf_rp_ff;
      case ({tbuf_push, tbuf_pop})
        2'b10: begin
          tbuf_cnt_ff <= tbuf_cnt_ff + 2'h1;
          tx_space_o  <= (tbuf_cnt_ff == 2'h0);
        end
        2'b01: begin
          tbuf_cnt_ff <= tbuf_cnt_ff - 2'h1;
          tx_space_o  <= 1'b1;
        end
        default: begin
          tbuf_cnt_ff <= tbuf_cnt_ff;
          tx_space_o  <= tx_space_o;
        end
      endcase
    end
  end

  // storage has no reset: contents matter only while counted valid
  always_ff @(posedge clk_i) begin
    if (tbuf_push)
      tbuf_mem[tbuf_wp_ff] <= wdata_i;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  asu_tx_e    tx_st_ff;
  logic [7:0] tx_shift_reg_ff;
  logic [2:0] tx_sub_ff;
  logic [2:0] tx_bit_ff;
  logic       tx_par_ff;
  logic       tx_bit_end;

  assign tx_bit_end = tick && (tx_sub_ff == `ASU_TICKS_BIT);
  assign tbuf_pop   = (tx_st_ff == TX_IDLE) && fmt.tx_en && tbuf_valid;

  // frame sequencer; clearing transmit enable aborts to idle high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st_ff        <= TX_IDLE;
      tx_shift_reg_ff <= 8'hFF;
      tx_sub_ff       <= 3'h0;
      tx_bit_ff       <= 3'h0;
      tx_par_ff       <= 1'b0;
      txd_o           <= 1'b1;
      tx_done_irq_o   <= 1'b0;
    end else begin
      tx_done_irq_o <= 1'b0;
      if (tick)
        tx_sub_ff <= tx_sub_ff + 3'h1;
      if (!fmt.tx_en) begin
        tx_st_ff <= TX_IDLE;
        txd_o    <= 1'b1;
      end else begin
        case (tx_st_ff)
          TX_IDLE: begin
            txd_o <= 1'b1;
            if (tbuf_valid) begin
              tx_shift_reg_ff <= tbuf_mem[tbuf_rp_ff];
              tx_par_ff       <= par_bit(tbuf_mem[tbuf_rp_ff], fmt.par, fmt.len8);
              tx_sub_ff       <= 3'h0;
              tx_st_ff        <= TX_START;
              txd_o           <= 1'b0;
            end
          end
          TX_START: begin
            if (tx_bit_end) begin
              tx_st_ff  <= TX_DATA;
              tx_bit_ff <= 3'h0;
              txd_o     <= tx_shift_reg_ff[0];
            end
          end
          TX_DATA: begin
            if (tx_bit_end) begin
              tx_shift_reg_ff <= {1'b1, tx_shift_reg_ff[7:1]};
              tx_bit_ff       <= tx_bit_ff + 3'h1;
              if (tx_bit_ff == (fmt.len8 ? 3'h7 : 3'h6)) begin
                if (fmt.par == PAR_NONE) begin
                  tx_st_ff <= TX_STOP1;
                  txd_o    <= 1'b1;
                end else begin
                  tx_st_ff <= TX_PAR;
                  txd_o    <= tx_par_ff;
                end
              end else begin
                txd_o <= tx_shift_reg_ff[1];
              end
            end
          end
          TX_PAR: begin
            if (tx_bit_end) begin
              tx_st_ff <= TX_STOP1;
              txd_o    <= 1'b1;
            end
          end
          TX_STOP1: begin
            if (tx_bit_end) begin
              tx_st_ff      <= fmt.stop2 ? TX_STOP2 : TX_IDLE;
              tx_done_irq_o <= !fmt.stop2;
            end
          end
          TX_STOP2: begin
            if (tx_bit_end) begin
              tx_st_ff      <= TX_IDLE;
              tx_done_irq_o <= 1'b1;
            end
          end
          default: begin
            tx_st_ff <= TX_IDLE;
            txd_o    <= 1'b1;
          end
        endcase
      end
    end
  end

  // sticky completion flag; a new data write clears it, the set wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      tx_done_flag_o <= 1'b0;
    else if (tx_done_irq_o)
      tx_done_flag_o <= 1'b1;
    else if (wr_data)
      tx_done_flag_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  logic rx_meta_ff;
  logic rx_sync_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_line_pin_i;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  asu_rx_e    rx_st_ff;
  logic [7:0] rx_shift_ff;
  logic [2:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic       rx_pe_ff;
  logic       rx_fin;
  logic       rx_fin_ff;
  logic       rx_sample;
  logic       rx_par_err;

  assign rx_sample  = tick && (rx_cnt_ff == `ASU_TICKS_BIT);
  assign rx_fin     = (rx_st_ff == RX_STOP) && rx_sample && fmt.rx_en;
  assign rx_par_err = rx_pe_ff && (fmt.par != PAR_NONE) && (fmt.par != PAR_ZERO);

  // start detection and bit sampling at mid-bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_ff    <= RX_IDLE;
      rx_shift_ff <= 8'h00;
      rx_cnt_ff   <= 3'h0;
      rx_bit_ff   <= 3'h0;
      rx_pe_ff    <= 1'b0;
    end else if (!fmt.rx_en) begin
      rx_st_ff <= RX_IDLE;
    end else begin
      if (tick)
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          if (!rx_sync_ff) begin
            rx_st_ff  <= RX_START;
            rx_cnt_ff <= 3'h0;
          end
        end
        RX_START: begin
          if (tick && (rx_cnt_ff == `ASU_TICKS_HALF)) begin
            rx_cnt_ff   <= 3'h0;
            rx_bit_ff   <= 3'h0;
            rx_shift_ff <= 8'h00;
            rx_st_ff    <= rx_sync_ff ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift_ff[rx_bit_ff] <= rx_sync_ff;
            rx_bit_ff              <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == (fmt.len8 ? 3'h7 : 3'h6))
              rx_st_ff <= (fmt.par == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          if (rx_sample) begin
            rx_pe_ff <= rx_sync_ff ^ par_bit(rx_shift_ff, PAR_EVEN, 1'b1)
                        ^ (fmt.par == PAR_ODD);
            rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_st_ff <= RX_IDLE;
            rx_pe_ff <= 1'b0;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // frame end: copy to buffer, errors replace old status, set beats read clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_buffer_ff       <= 8'h00;
      rx_error_status_ff <= '0;
      rx_unread_ff       <= 1'b0;
    end else if (rx_fin) begin
      rx_buffer_ff               <= rx_shift_ff;
      rx_error_status_ff.parity  <= rx_par_err;
      rx_error_status_ff.framing <= !rx_sync_ff;
      rx_error_status_ff.overrun <= rx_unread_ff;
      rx_unread_ff               <= 1'b1;
    end else if (rd_data) begin
      rx_error_status_ff <= '0;
      rx_unread_ff       <= 1'b0;
    end
  end

  // the interrupt follows one cycle later and needs receive enable still set,
  // giving the late-disable window where the buffer changes without an irq
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_fin_ff     <= 1'b0;
      rx_done_irq_o <= 1'b0;
    end else begin
      rx_fin_ff     <= rx_fin;
      rx_done_irq_o <= rx_fin_ff && fmt.rx_en;
    end
  end

endmodule // asu_uart

/* File: testbench/asu_remote.sv */
`timescale 1ns/100ps
module asu_remote (
  // clock
  input  wire logic clk_i,
  // line pins of the far station
  input  wire logic txd_i,
  output logic      rxd_o
);
  int bit_clks = 32;
  int nb = 9;
  int got_q[$];
  int v;
  initial rxd_o = 1'b1;
  // ----
  // sender
  // ----
  // start, character lsb first, optional parity, one stop
  task automatic send(input int d, input int len, input int pb, input int stop);
    int f;
    int n;
    f = (d & ((1 << len) - 1)) << 1;
    n = len + 1;
    if (pb >= 0) begin
      f = f | (pb << n);
      n++;
    end
    f = f | (stop << n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_i);
      #1 rxd_o = f[i];
      repeat (bit_clks - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    #1 rxd_o = 1'b1;
  endtask
  // ----
  // decoder
  // ----
  // mid-bit sampling; nb counts bits after the start bit
  always begin
    @(negedge txd_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    v = 0;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      v[i] = txd_i;
    end
    got_q.push_back(v);
  end
endmodule // asu_remote

/* File: testbench/asu_uart_assertions.sv */
`timescale 1ns/100ps
`include "asu_cfg.svh"
module asu_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        tx_space_o,
  // events and pins
  input wire logic        tx_done_irq_o,
  input wire logic        tx_done_flag_o,
  input wire logic        rx_done_irq_o,
  input wire logic        rx_line_pin_i,
  input wire logic        txd_o
);
  logic tx_en_ff;
  logic rx_en_ff;
  logic dwr;
  // ----
  // mode shadow
  // ----
  // a data write outside a done pulse clears the done flag, even one the full buffer drops
  assign dwr = wr_i && addr_i == `ASU_ADDR_DATA;
  // mirror the enables so pin checks know the mode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
    end else if (wr_i && addr_i == `ASU_ADDR_MODE) begin
      tx_en_ff <= wdata_i[`ASU_MODE_TXE];
      rx_en_ff <= wdata_i[`ASU_MODE_RXE];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----
  // properties
  // ----
  property p_tx_pulse; tx_done_irq_o |=> !tx_done_irq_o && tx_done_flag_o; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx done pulse");
  property p_flag_hold; tx_done_flag_o && !dwr |=> tx_done_flag_o; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("tx flag lost");
  property p_flag_clr; dwr && !tx_done_irq_o ##1 !tx_done_irq_o |-> !tx_done_flag_o; endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("tx flag kept");
  property p_tx_idle; !tx_en_ff |=> txd_o; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("line low while off");
  property p_tx_start; $fell(txd_o) |-> tx_en_ff || $past(tx_en_ff); endproperty
  a_tx_start: assert property (p_tx_start) else $error("start while off");
  property p_rx_quiet; !rx_en_ff [*3] |-> !rx_done_irq_o; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx irq while off");
  property p_rx_pulse; rx_done_irq_o |=> !rx_done_irq_o; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx done pulse");
  property p_rd_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_sync_rsv; rd_i && addr_i == `ASU_ADDR_SYNC |=> rdata_o[5:4] == 2'h0; endproperty
  a_sync_rsv: assert property (p_sync_rsv) else $error("sync reserved set");
  property p_stat_rsv; rd_i && addr_i == `ASU_ADDR_STATUS |=> rdata_o[7:3] == 5'h00; endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status unused set");
endmodule // asu_chk
bind asu_uart asu_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tx_space_o(tx_space_o),
  .tx_done_irq_o(tx_done_irq_o), .tx_done_flag_o(tx_done_flag_o), .rx_done_irq_o(rx_done_irq_o),
  .rx_line_pin_i(rx_line_pin_i), .txd_o(txd_o));

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`include "asu_cfg.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  rdata_o;
  logic        tx_space_o;
  logic        tx_done_irq_o;
  logic        tx_done_flag_o;
  logic        rx_done_irq_o;
  logic        rx_line_pin_i;
  logic        txd_o;
  logic [7:0]  rv;
  int          miscompares = 0;
  int          tests_run = 0;
  int          seed = 8;
  int          cycles = 0;
  int          rx_irqs = 0;
  int          pm, ln, s2, p, d, n0;
  int          bq[4];
  asu_uart u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .tx_space_o(tx_space_o), .tx_done_irq_o(tx_done_irq_o),
    .tx_done_flag_o(tx_done_flag_o), .rx_done_irq_o(rx_done_irq_o),
    .rx_line_pin_i(rx_line_pin_i), .txd_o(txd_o));
  asu_remote u_rem (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rx_line_pin_i));
  always #12.5 clk_i = ~clk_i;
  // ----
  // helpers
  // ----
  // receive events counted mid-cycle, where the pulse has settled
  always @(negedge clk_i) begin
    if (rx_done_irq_o === 1'b1) rx_irqs++;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dt);
    @(posedge clk_i);
    #1 {wr_i, addr_i, wdata_i} = {1'b1, a, dt};
    @(posedge clk_i);
    #1 wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] dt);
    @(posedge clk_i);
    #1 {rd_i, addr_i} = {1'b1, a};
    @(posedge clk_i);
    #1 rd_i = 1'b0;
    dt = rdata_o;
  endtask
  // waits for one done pulse, never forever
  task automatic wait_ev(input bit rx);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while ((rx ? rx_done_irq_o : tx_done_irq_o) !== 1'b1 && n < 3000);
    check("done wait", n < 3000, 1);
  endtask
  // bench model of the parity bit and of the bits after the start bit
  function automatic int par_of(int dt, int len, int m);
    int c;
    c = $countones(dt & ((1 << len) - 1)) & 1;
    return (m == 3) ? c : (m == 2) ? 1 - c : 0;
  endfunction
  function automatic int frame_of(int dt, int len, int m, int st2);
    int f;
    f = dt & ((1 << len) - 1);
    if (m != 0) f = f | (par_of(dt, len, m) << len);
    return f | ((st2 ? 3 : 1) << (len + (m != 0)));
  endfunction
  task automatic rx_frame(input int dt, input int pb, input int stop);
    fork
      u_rem.send(dt, ln, pb, stop);
      wait_ev(1);
    join
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    // reset values, reserved bits and unmapped neighbours all read zero
    for (int a = 16'hFF6F; a <= 16'hFF75; a++) begin
      rd(16'(a), rv);
      check("reset read", rv, 8'h00);
    end
    wr(`ASU_ADDR_SYNC, 8'hFF);
    rd(`ASU_ADDR_SYNC, rv);
    check("sync ctrl", rv, 8'hCF);
    // every parity mode and length both ways; last pass at the slower divider
    for (int i = 0; i < 9; i++) begin
      {pm, ln, s2} = {i % 4, (i < 4) ? 7 : 8, (i / 2) % 2};
      if (i == 8) begin
        wr(`ASU_ADDR_BAUD, 8'h10);
        u_rem.bit_clks = 64;
      end
      wr(`ASU_ADDR_MODE, 8'(8'hC0 | (pm << 4) | ((ln - 7) << 3) | (s2 << 2)));
      u_rem.nb = ln + (pm != 0) + 1 + s2;
      d = $random(seed);
      wr(`ASU_ADDR_DATA, d[7:0]);
      wait_ev(0);
      // the sticky flag follows the pulse by one clock
      @(posedge clk_i);
      #1 check("tx flag", tx_done_flag_o, 1);
      check("tx frame", u_rem.got_q.pop_front(), frame_of(d, ln, pm, s2));
      for (int bad = 0; bad < 2; bad++) begin
        d = $random(seed);
        p = (pm == 0) ? -1 : par_of(d, ln, pm) ^ bad;
        rx_frame(d, p, 1);
        rd(`ASU_ADDR_STATUS, rv);
        check("rx status", rv, (bad && pm >= 2) ? 4 : 0);
        rd(`ASU_ADDR_DATA, rv);
        check("rx data", rv, d & ((1 << ln) - 1));
      end
    end
    wr(`ASU_ADDR_BAUD, 8'h00);
    u_rem.bit_clks = 32;
    u_rem.nb = 9;
    // missing stop bit, then overrun, then a read clears status
    wr(`ASU_ADDR_MODE, 8'hC8);
    rx_frame(8'h5A, -1, 0);
    rd(`ASU_ADDR_STATUS, rv);
    check("framing", rv, 8'h02);
    rd(`ASU_ADDR_DATA, rv);
    check("framed data", rv, 8'h5A);
    wr(`ASU_ADDR_MODE, 8'h88);
    wr(`ASU_ADDR_MODE, 8'hC8);
    rx_frame(8'h11, -1, 1);
    rx_frame(8'h22, -1, 1);
    rd(`ASU_ADDR_STATUS, rv);
    check("overrun", rv, 8'h01);
    rd(`ASU_ADDR_DATA, rv);
    rd(`ASU_ADDR_STATUS, rv);
    check("status cleared", rv, 8'h00);
    // receive switched off mid-frame
    n0 = rx_irqs;
    fork
      u_rem.send(8'h77, 8, -1, 1);
      begin
        repeat (150) @(posedge clk_i);
        wr(`ASU_ADDR_MODE, 8'h88);
      end
    join
    check("abort irq", rx_irqs, n0);
    // buffer is read only with reception enabled again
    wr(`ASU_ADDR_MODE, 8'hC8);
    rd(`ASU_ADDR_DATA, rv);
    check("abort data", rv, 8'h22);
    // transmit switched off mid-frame, then the recovery sequence
    wr(`ASU_ADDR_DATA, 8'h00);
    repeat (100) @(posedge clk_i);
    wr(`ASU_ADDR_MODE, 8'h48);
    repeat (3) @(posedge clk_i);
    #1 check("abort line", txd_o, 1);
    repeat (400) @(posedge clk_i);
    wr(`ASU_ADDR_DATA, 8'hFF);
    wr(`ASU_ADDR_MODE, 8'hC8);
    wait_ev(0);
    repeat (40) @(posedge clk_i);
    u_rem.got_q.delete();
    // fill the two-entry buffer, one more write is dropped
    for (int k = 0; k < 4; k++) begin
      bq[k] = $random(seed);
      wr(`ASU_ADDR_DATA, bq[k][7:0]);
      if (k == 0) repeat (4) @(posedge clk_i);
      if (k == 2) check("tx space", tx_space_o, 0);
    end
    for (int k = 0; k < 3; k++) begin
      wait_ev(0);
      check("queued frame", u_rem.got_q.pop_front(), frame_of(bq[k], 8, 0, 0));
    end
    repeat (400) @(posedge clk_i);
    check("dropped write", u_rem.got_q.size(), 0);
    report_and_stop();
  end
endmodule // testbench
